// File: inc/osc_pkg.sv
package osc_pkg;
   // register byte offsets (apb)
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_TUNE = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_STARTUP = 8'h0c;
   // control register field positions
   localparam int CTL_SCS_LSB = 0;
   localparam int CTL_IRCF_LSB = 3;
   localparam int CTL_IRCF_W = 4;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [5:0] TUNE_RESET = 6'h00;
   // status bit positions
   localparam int ST_HF_READY = 0;
   localparam int ST_HF_LOCKED = 1;
   localparam int ST_HF_STABLE = 2;
   localparam int ST_MF_READY = 3;
   localparam int ST_LF_READY = 4;
   localparam int ST_OST_DONE = 5;
   localparam int ST_OST_RUN = 6;
   // configuration oscillator select codes
   localparam logic [2:0] FOSC_LP = 3'h0;
   localparam logic [2:0] FOSC_XT = 3'h1;
   localparam logic [2:0] FOSC_HS = 3'h2;
   localparam logic [2:0] FOSC_INTERNAL_OSC_CLOCK = 3'h4;
   // start-up count of external oscillations
   localparam int OST_COUNT = 1024;
   localparam int OST_W = 11;
   // settling times, in microseconds, after an oscillator is enabled
   localparam int HF_LOCK_US = 10;
   localparam int HF_STABLE_US = 40;
   localparam int OSC_RUN_US = 2;
   localparam int CLK_MHZ = 50;
   localparam int HF_LOCK_CYC = HF_LOCK_US * CLK_MHZ;
   localparam int HF_STABLE_CYC = HF_STABLE_US * CLK_MHZ;
   localparam int OSC_RUN_CYC = OSC_RUN_US * CLK_MHZ;
   // oscillator status carried as one group
   typedef struct packed {
      logic lf_ready_flag;
      logic mf_ready_flag;
      logic hf_stable_flag;
      logic hf_locked_flag;
      logic hf_ready_flag;
   } osc_flags_t;
   // apb request, decoded for every register
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } osc_req_t;
endpackage

// File: hdl/osc_settle.sv
`timescale 1ns/1ns
// counts cycles after enable, raises done at threshold, clears on disable
module osc_settle #(
   parameter int CYCLES = 100,
   parameter int W = 12
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic enable,
   output logic done
);
   logic [W-1:0] count;
   wire at_end = (count == W'(CYCLES - 1));

   // saturating counter, restarted when disabled
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !enable) begin
         count <= '0;
         done <= 1'b0;
      end else if (at_end) begin
         done <= 1'b1;
      end else begin
         count <= count + W'(1);
      end
   end
endmodule

// File: hdl/osc_ost.sv
`timescale 1ns/1ns
// start-up timer: counts rising edges of the synchronised external clock
module osc_ost #(
   parameter int COUNT = osc_pkg::OST_COUNT,
   parameter int W = osc_pkg::OST_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic ext_osc_input,
   output logic running,
   output logic done
);
   logic sync1;
   logic sync2;
   logic sync3;
   logic [W-1:0] edges;
   wire rise = sync2 & ~sync3;
   wire last = (edges == W'(COUNT - 1));

   // two-stage synchroniser, third stage for edge detect
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= ext_osc_input;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // edge counter, restarted by every start pulse
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         edges <= '0;
         running <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         edges <= '0;
         running <= 1'b1;
         done <= 1'b0;
      end else if (running && rise) begin
         if (last) begin
            running <= 1'b0; // RULE_01
            done <= 1'b1;
         end else begin
            edges <= edges + W'(1); // RULE_01
         end
      end
   end
endmodule

// File: hdl/osc_ctl.sv
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Function
// RULE_01: crystal modes count 1024 external oscillations before clock is stable.
// RULE_02: count starts after power-up delay expiry and on each sleep wake-up.
// RULE_03: execution stalls while counting unless fail-safe or two-speed enabled.
// RULE_04: high-frequency source is 16 MHz, output chosen by 4-bit select.
// RULE_05: high source enabled by high select with osc select 100 or source 1x.
// RULE_06: high ready flag set while high-frequency oscillator runs.
// RULE_07: high locked flag set once within 2 percent of final frequency.
// RULE_08: high stable flag set once within 0.5 percent of final frequency.
// RULE_09: medium source 500 kHz, nine postscaler outputs, same enable as high.
// RULE_10: medium ready flag set while medium-frequency oscillator runs.
// RULE_11: one tune value adjusts both high and medium sources together.
// RULE_12: tune is 6-bit two's complement, reset zero, 1Fh max, 20h min.
// RULE_13: tuning drifts while execution continues; no completion flag.
// RULE_14: tune never alters the low-frequency oscillator or its timers.
// RULE_15: low source 31 kHz, system clock when select 000 and source 1x.
// RULE_16: low source is timebase for power-up, watchdog and fail-safe.
// RULE_17: low ready flag set while low-frequency oscillator runs.
// RULE_18: status flags read-only and clear when their oscillator is disabled.
module osc_ctl #(
   parameter int HF_LOCK_CYC = osc_pkg::HF_LOCK_CYC,
   parameter int HF_STABLE_CYC = osc_pkg::HF_STABLE_CYC,
   parameter int OSC_RUN_CYC = osc_pkg::OSC_RUN_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // configuration and system events
   input wire logic [2:0] config_osc_select,
   input wire logic failsafe_en,
   input wire logic two_speed_en,
   input wire logic powerup_delay_done,
   input wire logic sleep_wakeup,
   input wire logic ext_osc_input,
   input wire logic lf_needed,
   // oscillator controls
   output logic hf_osc_enable,
   output logic mf_osc_enable,
   output logic lf_osc_enable,
   output logic [5:0] osc_trim,
   output logic [5:0] lf_trim,
   output logic [3:0] postscaler_sel,
   output logic use_internal_clock,
   output logic use_lf_clock,
   output logic lf_timebase_enable,
   output logic cpu_stall,
   output logic ext_clock_stable,
   output osc_pkg::osc_flags_t osc_status
);
   typedef enum logic [2:0] {
      OSC_ST_WAIT = 3'b001,
      OSC_ST_COUNT = 3'b010,
      OSC_ST_DONE = 3'b100
   } osc_state_t;

   osc_state_t state;
   osc_state_t next_state;
   logic [7:0] osc_control_reg;
   logic [5:0] freq_tune_value;
   logic pwr_seen;
   logic ost_start;
   logic ost_running;
   logic ost_done;
   logic hf_run;
   logic hf_locked;
   logic hf_stable;
   logic mf_run;
   logic lf_run;
   osc_pkg::osc_req_t req;

   // control register fields
   wire [1:0] sys_clock_source_sel = osc_control_reg[osc_pkg::CTL_SCS_LSB +: 2];
   wire [3:0] internal_freq_select =
      osc_control_reg[osc_pkg::CTL_IRCF_LSB +: osc_pkg::CTL_IRCF_W];
   wire scs_internal = sys_clock_source_sel[1];
   wire fosc_internal = (config_osc_select == osc_pkg::FOSC_INTERNAL_OSC_CLOCK);
   wire crystal_mode_on = (config_osc_select == osc_pkg::FOSC_LP) ||
      (config_osc_select == osc_pkg::FOSC_XT) ||
      (config_osc_select == osc_pkg::FOSC_HS);
   wire bypass_stall = failsafe_en || two_speed_en;
   // bypassed start-up count keeps code running on the internal clock
   wire run_on_internal_osc_clock = (state == OSC_ST_COUNT) && bypass_stall; // RULE_03
   wire internal_osc_clock_selected = scs_internal || fosc_internal || run_on_internal_osc_clock;
   wire sel_lf = (internal_freq_select[3:1] == 3'h0);
   wire sel_hf = internal_freq_select[3];
   wire sel_mf = !sel_lf && !sel_hf;

   // oscillator enables
   assign hf_osc_enable = internal_osc_clock_selected && sel_hf; // RULE_04 RULE_05
   assign mf_osc_enable = internal_osc_clock_selected && (sel_mf || sel_hf); // RULE_09
   assign lf_osc_enable = (internal_osc_clock_selected && sel_lf) || lf_needed
      || failsafe_en; // RULE_15 RULE_16
   assign lf_timebase_enable = lf_run; // RULE_16
   assign postscaler_sel = internal_freq_select; // RULE_04 RULE_09
   assign use_internal_clock = internal_osc_clock_selected; // RULE_03
   assign use_lf_clock = (scs_internal || run_on_internal_osc_clock) && sel_lf; // RULE_15

   // shared trim to 500 kHz core; low oscillator trim stays fixed
   assign osc_trim = freq_tune_value; // RULE_11 RULE_13
   assign lf_trim = osc_pkg::TUNE_RESET; // RULE_14

   // execution stall and external clock stable
   assign cpu_stall = (state == OSC_ST_COUNT) && !bypass_stall; // RULE_03
   assign ext_clock_stable = ost_done; // RULE_01

   // status, each flag gated by its oscillator enable
   assign osc_status.hf_ready_flag = hf_run && hf_osc_enable; // RULE_06 RULE_18
   assign osc_status.hf_locked_flag = hf_locked && hf_osc_enable; // RULE_07 RULE_18
   assign osc_status.hf_stable_flag = hf_stable && hf_osc_enable; // RULE_08 RULE_18
   assign osc_status.mf_ready_flag = mf_run && mf_osc_enable; // RULE_10 RULE_18
   assign osc_status.lf_ready_flag = lf_run && lf_osc_enable; // RULE_17 RULE_18

   // settling timers for each internal oscillator
   osc_settle #(.CYCLES(OSC_RUN_CYC), .W(16)) u_hf_run (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(hf_osc_enable),
      .done(hf_run)
   );
   osc_settle #(.CYCLES(HF_LOCK_CYC), .W(16)) u_hf_lock (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(hf_osc_enable),
      .done(hf_locked)
   );
   osc_settle #(.CYCLES(HF_STABLE_CYC), .W(16)) u_hf_stab (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(hf_osc_enable),
      .done(hf_stable)
   );
   osc_settle #(.CYCLES(OSC_RUN_CYC), .W(16)) u_mf_run (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(mf_osc_enable),
      .done(mf_run)
   );
   osc_settle #(.CYCLES(OSC_RUN_CYC), .W(16)) u_lf_run (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(lf_osc_enable),
      .done(lf_run)
   );

   // start-up timer on the external oscillator
   osc_ost u_ost (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(ost_start),
      .ext_osc_input(ext_osc_input),
      .running(ost_running),
      .done(ost_done)
   );

   // start pulse in crystal modes only: power-up delay expiry once, or every wake-up
   wire pwr_event = powerup_delay_done && !pwr_seen;
   assign ost_start = crystal_mode_on && (pwr_event || sleep_wakeup); // RULE_02

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pwr_seen <= 1'b0;
      end else if (powerup_delay_done) begin
         pwr_seen <= 1'b1;
      end
   end

   // start-up sequencer
   always_comb begin
      next_state = state;
      case (state)
         OSC_ST_WAIT: begin
            if (ost_start) begin
               next_state = OSC_ST_COUNT;
            end
         end
         OSC_ST_COUNT: begin
            if (!ost_running && !ost_start) begin
               next_state = OSC_ST_DONE;
            end
         end
         OSC_ST_DONE: begin
            if (ost_start) begin
               next_state = OSC_ST_COUNT; // RULE_02
            end
         end
         default: next_state = OSC_ST_WAIT;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= OSC_ST_WAIT;
      end else begin
         state <= next_state;
      end
   end

   // apb decode
   assign req.addr = paddr;
   assign req.write = pwrite;
   assign req.wdata = pwdata;
   wire access = psel && penable;
   wire hit_ctl = (req.addr == osc_pkg::ADDR_CONTROL);
   wire hit_tune = (req.addr == osc_pkg::ADDR_TUNE);
   wire hit_stat = (req.addr == osc_pkg::ADDR_STATUS);
   wire hit_st = (req.addr == osc_pkg::ADDR_STARTUP);
   wire mapped = hit_ctl || hit_tune || hit_stat || hit_st;
   wire wr_ok = access && req.write;
   assign pready = 1'b1;
   wire bad_addr = access && !mapped;
   wire ro_write = access && req.write && (hit_stat || hit_st); // RULE_18
   assign pslverr = bad_addr || ro_write;

   // writable registers; status is read-only
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         osc_control_reg <= osc_pkg::CTL_RESET;
         freq_tune_value <= osc_pkg::TUNE_RESET; // RULE_12
      end else if (wr_ok && hit_ctl) begin
         osc_control_reg <= req.wdata[7:0];
      end else if (wr_ok && hit_tune) begin
         freq_tune_value <= req.wdata[5:0]; // RULE_11 RULE_12
      end
   end

   // read data, registered on the setup cycle
   wire [31:0] stat_word = {25'h0, ost_running, ost_done,
      osc_status.lf_ready_flag, osc_status.mf_ready_flag,
      osc_status.hf_stable_flag, osc_status.hf_locked_flag,
      osc_status.hf_ready_flag}; // RULE_18
   wire [31:0] next_rdata = hit_ctl ? {24'h0, osc_control_reg} :
      hit_tune ? {26'h0, freq_tune_value} :
      hit_stat ? stat_word :
      hit_st ? {29'h0, state} : 32'h0;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end
endmodule

// File: dv/osc_ctl_asserts.sv
`timescale 1ns/1ns
// watches oscillator control outputs against their causes
module osc_ctl_asserts #(
   parameter int HF_STABLE_CYC = 8,
   parameter int OSC_RUN_CYC = 2
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [2:0] config_osc_select,
   input wire logic failsafe_en,
   input wire logic two_speed_en,
   input wire logic hf_osc_enable,
   input wire logic mf_osc_enable,
   input wire logic [5:0] lf_trim,
   input wire logic [3:0] postscaler_sel,
   input wire logic cpu_stall,
   input wire logic ext_clock_stable,
   input wire osc_pkg::osc_flags_t osc_status
);
   localparam int RDY_MAX = OSC_RUN_CYC + 2;
   localparam int STB_MAX = HF_STABLE_CYC + 2;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // high source switched on
   sequence s_hf_on;
      $rose(hf_osc_enable);
   endsequence
   // start-up count over, no bypass active
   sequence s_count_end;
      $fell(cpu_stall) && !failsafe_en && !two_speed_en;
   endsequence
   // enable decode and flag timing
   a_hf_enable_on: assert property (postscaler_sel[3] &&
      config_osc_select == osc_pkg::FOSC_INTERNAL_OSC_CLOCK |-> hf_osc_enable)
      else $error("hf source not enabled");
   a_hf_enable_off: assert property (!postscaler_sel[3] |->
      !hf_osc_enable) else $error("hf source on for low select");
   a_mf_enable_on: assert property (!postscaler_sel[3] &&
      postscaler_sel[2:1] != 2'h0 &&
      config_osc_select == osc_pkg::FOSC_INTERNAL_OSC_CLOCK |-> mf_osc_enable)
      else $error("mf source not enabled");
   a_hf_flags_clear: assert property (!hf_osc_enable |->
      !(osc_status.hf_ready_flag || osc_status.hf_locked_flag ||
      osc_status.hf_stable_flag)) else $error("hf flag while off");
   a_mf_flag_clear: assert property (!mf_osc_enable |->
      !osc_status.mf_ready_flag) else $error("mf flag while off");
   a_hf_ready_time: assert property (s_hf_on |->
      ##[1:RDY_MAX] (osc_status.hf_ready_flag || !hf_osc_enable))
      else $error("hf ready late");
   a_hf_stable_time: assert property (s_hf_on |->
      ##[1:STB_MAX] (osc_status.hf_stable_flag || !hf_osc_enable))
      else $error("hf stable late");
   a_lock_before_stable: assert property (
      osc_status.hf_stable_flag |->
      osc_status.hf_locked_flag && osc_status.hf_ready_flag)
      else $error("stable without lock");
   a_lf_trim_fixed: assert property (lf_trim == 6'h00)
      else $error("low trim moved");
   a_stall_bypass: assert property (failsafe_en || two_speed_en |->
      !cpu_stall) else $error("stall during bypass");
   a_stable_at_end: assert property (s_count_end |->
      ##[0:1] ext_clock_stable) else $error("stall ended unstable");
endmodule
bind osc_ctl osc_ctl_asserts #(.HF_STABLE_CYC(HF_STABLE_CYC),
   .OSC_RUN_CYC(OSC_RUN_CYC)) u_asserts (.clk_sys(clk_sys),
   .rst_n(rst_n), .config_osc_select(config_osc_select),
   .failsafe_en(failsafe_en), .two_speed_en(two_speed_en),
   .hf_osc_enable(hf_osc_enable), .mf_osc_enable(mf_osc_enable),
   .lf_trim(lf_trim), .postscaler_sel(postscaler_sel),
   .cpu_stall(cpu_stall), .ext_clock_stable(ext_clock_stable),
   .osc_status(osc_status));

// File: dv/osc_xtal_model.sv
`timescale 1ns/1ns
// crystal stand-in: a burst of oscillations, then stands still low
module osc_xtal_model (
   input wire logic start,
   input wire logic [10:0] n_edges,
   input wire logic [7:0] half_ns,
   output logic ext_osc_input,
   output logic busy
);
   initial begin
      ext_osc_input = 1'b0;
      busy = 1'b0;
   end
   // one burst per start pulse
   always @(posedge start) begin
      busy = 1'b1;
      #5; // keep pin edges clear of clock edges
      repeat (n_edges) begin
         #(half_ns) ext_osc_input = 1'b1;
         #(half_ns) ext_osc_input = 1'b0;
      end
      busy = 1'b0;
   end
endmodule

// File: dv/osc_ctl_tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the oscillator control block
module osc_ctl_tb_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [2:0] cfg = osc_pkg::FOSC_XT;
   logic two_spd = 1'b0;
   logic fs = 1'b0;
   logic lf_need = 1'b0;
   logic pwr_done = 1'b0;
   logic wake = 1'b0;
   logic x_start = 1'b0;
   logic [10:0] x_edges = 11'h000;
   logic [7:0] x_half = 8'h32;
   logic ext_osc, x_busy, hf_en, mf_en, use_lf, stall, stable;
   logic lf_en, lf_tb, use_int;
   logic [5:0] trim, lf_trim;
   logic [3:0] ps_sel;
   osc_pkg::osc_flags_t status;
   int error_cnt = 0;
   int checks = 0;
   always #10 clk_sys = ~clk_sys;
   osc_ctl #(.HF_LOCK_CYC(4), .HF_STABLE_CYC(8), .OSC_RUN_CYC(2)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .config_osc_select(cfg),
      .failsafe_en(fs), .two_speed_en(two_spd),
      .powerup_delay_done(pwr_done), .sleep_wakeup(wake),
      .ext_osc_input(ext_osc), .lf_needed(lf_need), .hf_osc_enable(hf_en),
      .mf_osc_enable(mf_en), .lf_osc_enable(lf_en), .osc_trim(trim),
      .lf_trim(lf_trim), .postscaler_sel(ps_sel), .use_internal_clock(use_int),
      .use_lf_clock(use_lf), .lf_timebase_enable(lf_tb), .cpu_stall(stall),
      .ext_clock_stable(stable), .osc_status(status));
   osc_xtal_model u_xtal (.start(x_start), .n_edges(x_edges),
      .half_ns(x_half), .ext_osc_input(ext_osc), .busy(x_busy));
   // compare and count
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic timeout();
      error_cnt++;
      $display("[FAIL] wait expected done seen hang");
      test_done();
   endtask
   // one apb transfer, result in rd and err
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (i == 16) timeout();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // crystal burst of n rising edges
   task automatic xtal(input logic [10:0] n, input logic [7:0] h);
      int i;
      x_edges <= n;
      x_half <= h;
      x_start <= 1'b1;
      @(posedge clk_sys);
      x_start <= 1'b0;
      for (i = 0; i < 20000; i++) begin
         @(posedge clk_sys);
         if (x_busy === 1'b0) break;
      end
      if (i == 20000) timeout();
      repeat (10) @(posedge clk_sys);
   endtask
   task automatic t_regs();
      apb(1'b0, osc_pkg::ADDR_TUNE, 32'h0);
      chk("tune reset", rd, 32'h0);
      apb(1'b0, osc_pkg::ADDR_STATUS, 32'h0);
      chk("status reset", rd, 32'h0);
      apb(1'b1, osc_pkg::ADDR_TUNE, 32'h1f);
      apb(1'b0, osc_pkg::ADDR_TUNE, 32'h0);
      chk("tune max", rd, 32'h1f);
      apb(1'b1, osc_pkg::ADDR_TUNE, 32'h20);
      apb(1'b0, osc_pkg::ADDR_TUNE, 32'h0);
      chk("tune min", rd, 32'h20);
      chk("trim out", 32'(trim), 32'h20);
      chk("lf trim", 32'(lf_trim), 32'h0);
      apb(1'b1, osc_pkg::ADDR_STATUS, 32'h1f);
      chk("status write", 32'(err), 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'(err), 32'h1);
      chk("unmapped rd", rd, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_ost();
      pwr_done <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("stall on", 32'(stall), 32'h1);
      xtal(11'd1023, 8'h32);
      chk("stall 1023", 32'(stall), 32'h1);
      chk("early stable", 32'(stable), 32'h0);
      xtal(11'd1, 8'h32);
      chk("stall off", 32'(stall), 32'h0);
      chk("stable", 32'(stable), 32'h1);
      two_spd <= 1'b1;
      wake <= 1'b1;
      @(posedge clk_sys);
      wake <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("bypass", 32'(stall), 32'h0);
      chk("restart", 32'(stable), 32'h0);
      xtal(11'd1024, 8'h46);
      chk("wake stable", 32'(stable), 32'h1);
      two_spd <= 1'b0;
      $display("t_ost done");
   endtask
   task automatic t_osc();
      logic [7:0] ctl [3] = '{8'h42, 8'h22, 8'h02};
      logic [4:0] st [3] = '{5'h0f, 5'h08, 5'h10};
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, osc_pkg::ADDR_CONTROL, {24'h0, ctl[k]});
         repeat (12) @(posedge clk_sys);
         apb(1'b0, osc_pkg::ADDR_STATUS, 32'h0);
         chk("status", 32'(rd[4:0]), 32'(st[k]));
         chk("select", 32'(ps_sel), 32'(ctl[k][6:3]));
         chk("lf clock", 32'(use_lf), 32'(k == 2));
      end
      cfg <= osc_pkg::FOSC_INTERNAL_OSC_CLOCK;
      apb(1'b1, osc_pkg::ADDR_CONTROL, 32'h40);
      @(posedge clk_sys);
      chk("hf by config", 32'(hf_en), 32'h1);
      apb(1'b1, osc_pkg::ADDR_CONTROL, 32'h20);
      @(posedge clk_sys);
      chk("mf by config", 32'(mf_en), 32'h1);
      chk("hf off", 32'(hf_en), 32'h0);
      $display("t_osc done");
   endtask
   task automatic t_side();
      cfg <= osc_pkg::FOSC_XT;
      apb(1'b1, osc_pkg::ADDR_CONTROL, 32'h40);
      fs <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("lf by failsafe", 32'(lf_en), 32'h1);
      chk("lf timebase", 32'(lf_tb), 32'h1);
      chk("crystal clock", 32'(use_int), 32'h0);
      wake <= 1'b1;
      @(posedge clk_sys);
      wake <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("fs no stall", 32'(stall), 32'h0);
      chk("fs on internal_osc_clock", 32'(use_int), 32'h1);
      chk("fs hf runs", 32'(hf_en), 32'h1);
      fs <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("stall resumes", 32'(stall), 32'h1);
      chk("lf off", 32'(lf_en), 32'h0);
      lf_need <= 1'b1;
      @(posedge clk_sys);
      chk("lf by request", 32'(lf_en), 32'h1);
      lf_need <= 1'b0;
      $display("t_side done");
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_ost();
      t_osc();
      t_side();
      test_done();
   end
   // overall limit on run time
   initial begin
      #1500000;
      timeout();
   end
endmodule
